/* qdac_ctrl.sv */
// module: serial control of the quad converter, link shift logic and command execution
`timescale 1ns/10ps
`default_nettype none
module qdac_ctrl (
   input  wire logic                                             mclk_i,
   input  wire logic                                             nrst_i,
   input  wire logic                                             sclk_i,
   input  wire logic                                             cs_n_i,
   input  wire logic                                             din_i,
   output var  logic                                             dout_o,
   input  wire logic                                             load_outputs_n_i,
   input  wire logic                                             clear_n_i,
   output var  logic                                             mode_rise_o,
   output var  logic [qdac_pkg::NCHAN-1:0][qdac_pkg::CODE_W-1:0] input_code_o,
   output var  logic [qdac_pkg::NCHAN-1:0][qdac_pkg::CODE_W-1:0] conv_code_o
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////////////////////////////////
   qdac_bank_if                    bus ();
   logic [qdac_pkg::WORD_W-1:0]    sr_r;
   logic                           fall_r;
   logic                           mode_link;
   logic [3:0]                     run_r;
   logic                           cs_s;
   logic                           clear_s;
   logic                           ldo_s;
   qdac_pkg::qdac_seq_t            seq_r;
   logic [qdac_pkg::WORD_W-1:0]    word_r;
   logic                           mode_r;
   logic                           exec;
   logic [1:0]                     cmd;
   logic [1:0]                     sel;
   logic                           is_rise_cmd;
   logic                           is_fall_cmd;
   logic                           is_nop;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // link domain: shift register and output retiming
   ////////////////////////////////////////////////////////////////////////////////////////////////

   // shift in on rising edges while selected, first bit toward the far end
   always_ff @(posedge sclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sr_r <= qdac_pkg::WORD_RST;
      else if (!cs_n_i)
         sr_r <= {sr_r[qdac_pkg::WORD_W-2:0], din_i};
   end

   // half-cycle retime of the last stage for falling phase
   always_ff @(negedge sclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         fall_r <= 1'b0;
      else if (!cs_n_i)
         fall_r <= sr_r[qdac_pkg::WORD_W-1];
   end

   // phase select brought into the link domain
   qdac_sync #(
      .RST_VAL (qdac_pkg::MODE_RST)
   ) u_mode_sync (
      .clk_i   (sclk_i),
      .nrst_i  (nrst_i),
      .d_i     (mode_r),
      .q_o     (mode_link)
   );

   // output taps the end of the shift register, never floats
   assign dout_o = mode_link ? sr_r[qdac_pkg::WORD_W-1] : fall_r;

   // count of shifting edges within the current frame, for checks only
   always_ff @(posedge sclk_i or negedge nrst_i or posedge cs_n_i)
   begin
      if (!nrst_i)
         run_r <= qdac_pkg::RUN_RST;
      else if (cs_n_i)
         run_r <= qdac_pkg::RUN_RST;
      else if (run_r != qdac_pkg::RUN_MAX)
         run_r <= run_r + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // system domain: pin synchronisers
   ////////////////////////////////////////////////////////////////////////////////////////////////

   // chip select, sampled for frame end
   qdac_sync #(
      .RST_VAL (qdac_pkg::PIN_IDLE)
   ) u_cs_sync (
      .clk_i   (mclk_i),
      .nrst_i  (nrst_i),
      .d_i     (cs_n_i),
      .q_o     (cs_s)
   );

   // clear pin, active low
   qdac_sync #(
      .RST_VAL (qdac_pkg::PIN_IDLE)
   ) u_clear_sync (
      .clk_i   (mclk_i),
      .nrst_i  (nrst_i),
      .d_i     (clear_n_i),
      .q_o     (clear_s)
   );

   // load-outputs pin, active low
   qdac_sync #(
      .RST_VAL (qdac_pkg::PIN_IDLE)
   ) u_ldo_sync (
      .clk_i   (mclk_i),
      .nrst_i  (nrst_i),
      .d_i     (load_outputs_n_i),
      .q_o     (ldo_s)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // system domain: frame sequencing and word capture
   ////////////////////////////////////////////////////////////////////////////////////////////////

   // idle until selected, execute once select rises
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         seq_r <= qdac_pkg::SEQ_IDLE;
      else
      begin
         case (seq_r)
            qdac_pkg::SEQ_IDLE:
               if (!cs_s)
                  seq_r <= qdac_pkg::SEQ_FRAME;
            qdac_pkg::SEQ_FRAME:
               if (cs_s)
                  seq_r <= qdac_pkg::SEQ_EXEC;
            qdac_pkg::SEQ_EXEC:
               seq_r <= qdac_pkg::SEQ_IDLE;
            default:
               seq_r <= qdac_pkg::SEQ_IDLE;
         endcase
      end
   end

   // word is quiet once select is high and the shift clock idles
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         word_r <= qdac_pkg::WORD_RST;
      else if (seq_r == qdac_pkg::SEQ_FRAME && cs_s)
         word_r <= sr_r;
   end

   // field split of the captured word
   assign exec        = (seq_r == qdac_pkg::SEQ_EXEC);
   assign cmd         = word_r[qdac_pkg::CMD_HI_POS:qdac_pkg::CMD_LO_POS];
   assign sel         = word_r[qdac_pkg::SEL_HI_POS:qdac_pkg::SEL_LO_POS];
   assign is_rise_cmd = (cmd == qdac_pkg::CMD_SPECIAL) && (sel == 2'h3);
   assign is_fall_cmd = (cmd == qdac_pkg::CMD_SPECIAL) && (sel == 2'h2);
   assign is_nop      = (cmd == qdac_pkg::CMD_DIRECT) && word_r[qdac_pkg::SEL_LO_POS];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // system domain: command decode and phase register
   ////////////////////////////////////////////////////////////////////////////////////////////////

   // strobes into the channel bank, one cycle at execution
   always_comb
   begin
      bus.load_in   = '0;
      bus.load_conv = '0;
      bus.conv_all  = 1'b0;
      bus.xfer_all  = 1'b0;
      if (exec)
      begin
         case (cmd)
            qdac_pkg::CMD_LOAD_IN:
               bus.load_in[sel] = 1'b1;
            qdac_pkg::CMD_LOAD_BOTH:
            begin
               bus.load_in[sel]   = 1'b1;
               bus.load_conv[sel] = 1'b1;
            end
            qdac_pkg::CMD_DIRECT:
               bus.conv_all = !is_nop;
            default:
               bus.xfer_all = 1'b1;
         endcase
      end
   end

   assign bus.data        = word_r[qdac_pkg::DATA_MSB:0];
   assign bus.clear       = !clear_s;
   assign bus.transparent = !ldo_s;

   // output phase, rising after power-up
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         mode_r <= qdac_pkg::MODE_RST;
      else if (exec && (is_rise_cmd || is_fall_cmd))
         mode_r <= word_r[qdac_pkg::SEL_LO_POS];
   end

   qdac_bank u_bank (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .bus     (bus)
   );

   assign mode_rise_o  = mode_r;
   assign input_code_o = bus.in_q;
   assign conv_code_o  = bus.conv_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // checks: system domain
   ////////////////////////////////////////////////////////////////////////////////////////////////

   mode_rise_set_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_rise_cmd |=> mode_r ##1 mode_rise_o)
      else $error("rising phase not set");

   xfer_rise_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_rise_cmd && clear_s |=> bus.conv_q == $past(bus.in_q))
      else $error("rising phase command did not transfer");

   mode_fall_set_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_fall_cmd |=> !mode_r)
      else $error("falling phase not set");

   mode_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !mode_r && !(exec && is_rise_cmd) |=> !mode_r)
      else $error("falling phase left without command");

   xfer_fall_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_fall_cmd && clear_s |=> bus.conv_q == $past(bus.in_q))
      else $error("falling phase command did not transfer");

   ldo_follow_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (!load_outputs_n_i && clear_n_i && !exec) [*3] |=> conv_code_o == $past(input_code_o))
      else $error("converter registers not transparent");

   clear_zero_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !clear_n_i ##2 !clear_s |=> conv_code_o == '0 && input_code_o == '0)
      else $error("clear did not zero registers");

   nop_keep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_nop && clear_s && ldo_s |=> $stable(conv_code_o) && $stable(input_code_o))
      else $error("pass-through word changed a register");

   exec_order_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      seq_r == qdac_pkg::SEQ_FRAME && cs_s |=> exec ##1 seq_r == qdac_pkg::SEQ_IDLE)
      else $error("command not executed at select rise");

   word_take_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      seq_r == qdac_pkg::SEQ_FRAME && cs_s |=> word_r == $past(sr_r))
      else $error("word not taken at select rise");

   load_field_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && cmd == qdac_pkg::CMD_LOAD_IN && clear_s
      |=> bus.in_q[$past(sel)] == $past(word_r[qdac_pkg::DATA_MSB:0]))
      else $error("input register load used wrong fields");

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // checks: link domain
   ////////////////////////////////////////////////////////////////////////////////////////////////

   dout_tap_a: assert property (@(posedge sclk_i) disable iff (!nrst_i)
      mode_link |-> dout_o == sr_r[qdac_pkg::WORD_W-1])
      else $error("output not from shift register end");

   lag_fall_a: assert property (@(posedge sclk_i) disable iff (!nrst_i)
      !mode_link && !cs_n_i && run_r >= qdac_pkg::LAG_CYC |-> dout_o == $past(din_i, 12))
      else $error("falling phase lag wrong");

   lag_fall_edge_a: assert property (@(negedge sclk_i) disable iff (!nrst_i)
      !mode_link && !cs_n_i |=> dout_o == $past(sr_r[qdac_pkg::WORD_W-1]))
      else $error("falling phase output not retimed");

   lag_rise_a: assert property (@(posedge sclk_i) disable iff (!nrst_i)
      mode_link && !cs_n_i && run_r >= qdac_pkg::LAG_CYC |-> dout_o == $past(din_i, 12))
      else $error("rising phase lag wrong");

   dout_hold_a: assert property (@(posedge sclk_i) disable iff (!nrst_i)
      cs_n_i ##1 cs_n_i && $stable(mode_link) |-> $stable(dout_o))
      else $error("output moved while deselected");

   shift_in_a: assert property (@(posedge sclk_i) disable iff (!nrst_i)
      !cs_n_i ##1 !cs_n_i |=> sr_r[1:0] == {$past(din_i, 2), $past(din_i)})
      else $error("serial input not shifted first bit first");

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // scenario coverage
   ////////////////////////////////////////////////////////////////////////////////////////////////

   fall_cmd_c: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_fall_cmd);

   rise_cmd_c: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_rise_cmd && !mode_r);

   nop_cmd_c: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      exec && is_nop);

   clear_c: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      !clear_s && conv_code_o != '0);

endmodule : qdac_ctrl
`default_nettype wire

/* qdac_pkg.sv */
// package: constants, command codes and reset values of the quad converter serial control
// Summary of operation
// - rising-phase command makes serial output change on rising edges; default after power-up
// - rising-phase command also copies every input register into its converter register
// - word 1,0 / 1,0 selects falling-phase; output then shifts on falling edges
// - falling phase holds until power cycle or the rising-phase command
// - falling-phase command also copies all input registers into converter registers
// - load-outputs low makes converter registers follow input registers from the third system clock on, after the pin synchroniser
// - clear low zeroes every input and converter register
// - serial output shows the bit leaving the end of the shift register
// - falling phase: output stream lags input stream by twelve and a half clocks
// - rising phase: output stream lags input stream by exactly twelve clocks
// - serial output never floats and holds its value while chip select is high
// - chained outputs feed next input; pass-through word alters no register
// - devices sharing chip select all execute together when it rises
// - word is twelve bits: two channel-select, two command, eight data bits
// - channel-select 1,1 with command 1,0 is the rising-phase command
// - commands act at chip select rise on the shift register contents then
`default_nettype none
package qdac_pkg;
   localparam int unsigned       WORD_W      = 12;
   localparam int unsigned       CODE_W      = 8;
   localparam int unsigned       NCHAN       = 4;
   localparam int unsigned       SEL_HI_POS  = 11;
   localparam int unsigned       SEL_LO_POS  = 10;
   localparam int unsigned       CMD_HI_POS  = 9;
   localparam int unsigned       CMD_LO_POS  = 8;
   localparam int unsigned       DATA_MSB    = 7;
   localparam logic [1:0]        CMD_DIRECT  = 2'h0;
   localparam logic [1:0]        CMD_LOAD_IN = 2'h1;
   localparam logic [1:0]        CMD_SPECIAL = 2'h2;
   localparam logic [1:0]        CMD_LOAD_BOTH = 2'h3;
   localparam logic              MODE_RISE   = 1'b1;
   localparam logic              MODE_RST    = 1'b1;
   localparam logic [WORD_W-1:0] WORD_RST    = 12'h000;
   localparam logic [CODE_W-1:0] CODE_RST    = 8'h00;
   localparam logic              PIN_IDLE    = 1'b1;
   localparam logic [3:0]        RUN_RST     = 4'h0;
   localparam logic [3:0]        RUN_MAX     = 4'hd;
   localparam logic [3:0]        LAG_CYC     = 4'hc;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_FRAME, SEQ_EXEC} qdac_seq_t;
endpackage : qdac_pkg
`default_nettype wire

/* qdac_bank_if.sv */
// interface: command strobes and register contents between control and channel bank
`timescale 1ns/10ps
`default_nettype none
interface qdac_bank_if;
   logic [qdac_pkg::NCHAN-1:0]                       load_in;
   logic [qdac_pkg::NCHAN-1:0]                       load_conv;
   logic                                             conv_all;
   logic                                             xfer_all;
   logic [qdac_pkg::CODE_W-1:0]                      data;
   logic                                             clear;
   logic                                             transparent;
   logic [qdac_pkg::NCHAN-1:0][qdac_pkg::CODE_W-1:0] in_q;
   logic [qdac_pkg::NCHAN-1:0][qdac_pkg::CODE_W-1:0] conv_q;
   modport ctrl (output load_in, load_conv, conv_all, xfer_all, data, clear, transparent,
                 input in_q, conv_q);
   modport bank (input load_in, load_conv, conv_all, xfer_all, data, clear, transparent,
                 output in_q, conv_q);
endinterface : qdac_bank_if
`default_nettype wire

/* qdac_sync.sv */
// module: two-flop level synchroniser with a chosen reset level
`timescale 1ns/10ps
`default_nettype none
module qdac_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic d_i,
   output var  logic q_o
);
   logic meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_r <= RST_VAL;
         q_o    <= RST_VAL;
      end
      else
      begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : qdac_sync
`default_nettype wire

/* qdac_bank.sv */
// module: four input registers and four converter registers
`timescale 1ns/10ps
`default_nettype none
module qdac_bank (
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   qdac_bank_if.bank       bus
);
   logic [qdac_pkg::CODE_W-1:0] in_r   [qdac_pkg::NCHAN];
   logic [qdac_pkg::CODE_W-1:0] conv_r [qdac_pkg::NCHAN];

   genvar ch;
   generate
      for (ch = 0; ch < qdac_pkg::NCHAN; ch++)
      begin : g_chan
         // input register of one channel
         always_ff @(posedge mclk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               in_r[ch] <= qdac_pkg::CODE_RST;
            else if (bus.clear)
               in_r[ch] <= qdac_pkg::CODE_RST;
            else if (bus.load_in[ch])
               in_r[ch] <= bus.data;
         end

         // converter register: direct data, transfer or transparent follow
         always_ff @(posedge mclk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               conv_r[ch] <= qdac_pkg::CODE_RST;
            else if (bus.clear)
               conv_r[ch] <= qdac_pkg::CODE_RST;
            else if (bus.load_conv[ch] || bus.conv_all)
               conv_r[ch] <= bus.data;
            else if (bus.transparent || bus.xfer_all)
               conv_r[ch] <= in_r[ch];
         end

         assign bus.in_q[ch]   = in_r[ch];
         assign bus.conv_q[ch] = conv_r[ch];
      end
   endgenerate
endmodule : qdac_bank
`default_nettype wire

/* qdac_host_model.sv */
// host serial port model: shift clock, chip select and data toward the converter
`timescale 1ns/10ps
`default_nettype none
module qdac_host_model #(
   parameter realtime HALF = 15.0
) (
   output var  logic sclk_o,
   output var  logic cs_n_o,
   output var  logic din_o,
   input  wire logic dout_i
);
   // idle: clock parked low, device deselected
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one frame, polarity and phase zero, first bit first; dout caught in both phases
   task automatic xfer(input logic [11:0] w, output logic [11:0] hi, output logic [11:0] lo);
      #3.3;
      cs_n_o = 1'b0;
      for (int k = 11; k >= 0; k--)
      begin
         din_o = w[k];
         #(HALF);
         sclk_o = 1'b1;
         #(HALF / 2);
         hi[k] = dout_i;
         #(HALF / 2);
         sclk_o = 1'b0;
         #(HALF / 2);
         lo[k] = dout_i;
         #(HALF / 2);
      end
      din_o  = ~din_o; // released line must not look stale
      cs_n_o = 1'b1;
      #(4 * HALF);
   endtask : xfer
endmodule : qdac_host_model
`default_nettype wire

/* qdac_ctrl_tb.sv */
// self-checking bench of the quad converter serial control
`timescale 1ns/10ps
`default_nettype none
module qdac_ctrl_tb;
   logic                 mclk;
   logic                 nrst_n;
   logic                 sclk;
   logic                 cs_n;
   logic                 din;
   logic                 dout;
   logic                 load_outputs_n;
   logic                 clear_n;
   logic                 mode_rise;
   logic [3:0][7:0]      in_code;
   logic [3:0][7:0]      cv_code;
   logic [3:0][7:0]      in_m;
   logic [3:0][7:0]      cv_m;
   logic                 rise_m;
   logic [11:0]          prev_w;
   int                   err_count;
   int                   num_checks;
   ////////////////////////////////////////////////////////////////////////////////
   // design and host
   qdac_ctrl u_dut (
      .mclk_i           (mclk),
      .nrst_i           (nrst_n),
      .sclk_i           (sclk),
      .cs_n_i           (cs_n),
      .din_i            (din),
      .dout_o           (dout),
      .load_outputs_n_i (load_outputs_n),
      .clear_n_i        (clear_n),
      .mode_rise_o      (mode_rise),
      .input_code_o     (in_code),
      .conv_code_o      (cv_code)
   );
   qdac_host_model u_host (
      .sclk_o (sclk),
      .cs_n_o (cs_n),
      .din_o  (din),
      .dout_i (dout)
   );
   // 100 MHz system clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // compare and report
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic chk_all();
      chk("mode", {31'h0, rise_m}, {31'h0, mode_rise});
      chk("input codes", in_m, in_code);
      chk("converter codes", cv_m, cv_code);
   endtask : chk_all
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////////
   // one command frame: readback of the previous word, then register effects
   task automatic cmd(input logic [11:0] w);
      logic [11:0] hi;
      logic [11:0] lo;
      logic [1:0]  sel;
      sel = w[11:10];
      u_host.xfer(w, hi, lo);
      chk("readback low", {22'h0, prev_w[8:0], w[11]}, {22'h0, lo[9:0]});
      chk("readback high", {22'h0, rise_m ? {prev_w[8:0], w[11]} : prev_w[9:0]}, {22'h0, hi[9:0]});
      repeat (6) @(negedge mclk);
      chk("dout held", {31'h0, w[11]}, {31'h0, dout});
      if (w[9:8] == 2'h1 || w[9:8] == 2'h3) in_m[sel] = w[7:0];
      if (w[9:8] == 2'h3) cv_m[sel] = w[7:0];
      if (w[9:8] == 2'h0 && !w[10]) cv_m = {4{w[7:0]}};
      if (w[9:8] == 2'h2) cv_m = in_m;
      if (w[9:8] == 2'h2 && w[11]) rise_m = w[10];
      if (!load_outputs_n) cv_m = in_m;
      prev_w = w;
      chk_all();
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      err_count = 0;
      num_checks = 0;
      nrst_n = 1'b0;
      load_outputs_n = 1'b1;
      clear_n = 1'b1;
      in_m = '0;
      cv_m = '0;
      rise_m = 1'b1;
      prev_w = '0;
      repeat (3) @(negedge mclk);
      nrst_n = 1'b1;
      repeat (3) @(negedge mclk);
      chk_all();
      for (int c = 0; c < 4; c++) cmd({c[1:0], 2'h1, 8'h3c + 8'(c)});
      cmd(12'ha5a);
      cmd(12'h1f0);
      cmd(12'h4c3);
      cmd(12'hf96);
      cmd(12'he69);
      cmd(12'h6e1);
      cmd(12'h2ff);
      cmd(12'h0c3);
      load_outputs_n = 1'b0;
      cmd(12'h9a7);
      load_outputs_n = 1'b1;
      repeat (3) @(negedge mclk);
      clear_n = 1'b0;
      repeat (4) @(negedge mclk);
      in_m = '0;
      cv_m = '0;
      chk_all();
      clear_n = 1'b1;
      finish_test();
   end
   // watchdog against a hung handshake
   initial
   begin
      #200us;
      err_count++;
      $display("timeout waiting for the tests");
      finish_test();
   end
endmodule : qdac_ctrl_tb
`default_nettype wire
